// >>> include/async_rx_pkg.sv
// constants and types of the serial receive port with address detection
package async_rx_pkg;

   // register byte offsets on the wishbone bus
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] STAT_OFS    = 8'h04;
   localparam logic [7:0] DATA_OFS    = 8'h08;
   localparam logic [7:0] DIV_OFS     = 8'h0c;
   localparam logic [7:0] EVT_OFS     = 8'h10;
   localparam logic [7:0] EVT_CLR_OFS = 8'h14;
   localparam logic [7:0] EVT_EN_OFS  = 8'h18;

   // control field positions
   localparam int CTRL_PORT_EN_BIT = 0;
   localparam int CTRL_CONT_EN_BIT = 1;
   localparam int CTRL_NINE_EN_BIT = 2;
   localparam int CTRL_ADDR_EN_BIT = 3;

   // status field positions
   localparam int ST_FRAME_BIT   = 0;
   localparam int ST_OVERRUN_BIT = 1;
   localparam int ST_NINTH_BIT   = 2;
   localparam int ST_RXFLAG_BIT  = 3;
   localparam int ST_COUNT_LSB   = 4;
   localparam int ST_BUSY_BIT    = 6;

   // event bits, shared by status, clear and enable registers
   localparam int EVT_RX_BIT  = 0;
   localparam int EVT_OVR_BIT = 1;
   localparam int EVT_W       = 2;

   // reset values
   localparam logic [3:0]       CTRL_RESET   = 4'h0;
   localparam logic [15:0]      DIV_RESET    = 16'h06c8;
   localparam logic [EVT_W-1:0] EVT_EN_RESET = 2'h0;

   // receive fifo depth, fixed at two characters
   localparam int FIFO_DEPTH = 2;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_phase_t;

   typedef struct packed {
      logic       frame_err;
      logic [8:0] data;
   } rx_entry_t;

   typedef struct packed {
      logic                       port_en;
      logic                       cont_en;
      logic                       nine_en;
      logic                       addr_en;
      logic [15:0]                divisor;
      logic [EVT_W-1:0]           evt_en;
      logic [EVT_W-1:0]           evt_stat;
      logic                       sync1;
      logic                       sync2;
      logic                       prev;
      rx_phase_t                  phase;
      logic [15:0]                cnt;
      logic [3:0]                 nbit;
      logic [8:0]                 shreg;
      rx_entry_t [FIFO_DEPTH-1:0] fifo;
      logic [1:0]                 count;
      logic                       overrun;
      logic                       ack;
      logic [31:0]                rdata;
      logic                       irq;
      logic                       rx_flag;
   } state_t;

endpackage

// >>> core/async_rx.sv
// serial receive port: two-deep fifo, error flags, 9-bit and address mode
`timescale 1ns/100ps
`default_nettype none

module async_rx
   import async_rx_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // serial line
   input  wire logic        rx_pin,
   // interrupt and receive flag
   output logic             irq,
   output logic             receive_interrupt_flag
);

   state_t           s;
   state_t           next_s;
   logic             req;
   logic             pop;
   logic             push;
   logic             done;
   logic             rx_on;
   logic [8:0]       ch;
   logic [31:0]      rd;
   logic [1:0]       left;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   rx_entry_t        entry_in;

   always_comb begin
      next_s   = s;
      pop      = 1'b0;
      push     = 1'b0;
      done     = 1'b0;
      rd       = 32'h0;
      evt_set  = '0;
      evt_clr  = '0;
      entry_in = '0;
      ch       = 9'h000;

      // line synchroniser, first stage feeds only the second
      next_s.sync1 = rx_pin;
      next_s.sync2 = s.sync1;
      next_s.prev  = s.sync2;

      // bus: one wait state, ack is a single-cycle pulse
      req        = cyc_i & stb_i & ~s.ack;
      next_s.ack = req;
      if (req && we_i) begin
         case (adr_i)
            CTRL_OFS: begin
               if (sel_i[0]) begin
                  next_s.port_en = dat_i[CTRL_PORT_EN_BIT];
                  next_s.cont_en = dat_i[CTRL_CONT_EN_BIT];
                  next_s.nine_en = dat_i[CTRL_NINE_EN_BIT];
                  next_s.addr_en = dat_i[CTRL_ADDR_EN_BIT];
               end
            end
            DIV_OFS: begin
               if (sel_i[0]) begin
                  next_s.divisor[7:0] = dat_i[7:0];
               end
               if (sel_i[1]) begin
                  next_s.divisor[15:8] = dat_i[15:8];
               end
            end
            EVT_CLR_OFS: begin
               if (sel_i[0]) begin
                  evt_clr = dat_i[EVT_W-1:0];
               end
            end
            EVT_EN_OFS: begin
               if (sel_i[0]) begin
                  next_s.evt_en = dat_i[EVT_W-1:0];
               end
            end
            default: ;
         endcase
      end else if (req) begin
         case (adr_i)
            CTRL_OFS: begin
               rd[CTRL_PORT_EN_BIT] = s.port_en;
               rd[CTRL_CONT_EN_BIT] = s.cont_en;
               rd[CTRL_NINE_EN_BIT] = s.nine_en;
               rd[CTRL_ADDR_EN_BIT] = s.addr_en;
            end
            STAT_OFS: begin
               // framing and ninth-bit flags follow the oldest unread entry
               rd[ST_FRAME_BIT]   = (s.count != 2'd0) & s.fifo[0].frame_err;
               rd[ST_NINTH_BIT]   = (s.count != 2'd0) & s.fifo[0].data[8];
               rd[ST_OVERRUN_BIT] = s.overrun;
               rd[ST_RXFLAG_BIT]  = s.rx_flag;
               rd[ST_COUNT_LSB+:2] = s.count;
               rd[ST_BUSY_BIT]    = (s.phase != RX_IDLE);
            end
            DATA_OFS: begin
               rd[8:0] = s.fifo[0].data;
               // the read itself advances the fifo
               pop = (s.count != 2'd0);
            end
            DIV_OFS: begin
               rd[15:0] = s.divisor;
            end
            EVT_OFS: begin
               rd[EVT_W-1:0] = s.evt_stat;
            end
            EVT_EN_OFS: begin
               rd[EVT_W-1:0] = s.evt_en;
            end
            default: ;
         endcase
      end
      next_s.rdata = rd;

      // no new frame may start while overrun stands
      rx_on = s.port_en & s.cont_en & ~s.overrun;

      unique case (s.phase)
         RX_IDLE: begin
            if (rx_on && s.prev && !s.sync2) begin
               next_s.phase = RX_START;
               next_s.cnt   = s.divisor >> 1;
            end
         end
         RX_START: begin
            if (s.cnt != 16'h0) begin
               next_s.cnt = s.cnt - 16'h1;
            end else if (!s.sync2) begin
               next_s.phase = RX_DATA;
               next_s.cnt   = s.divisor - 16'h1;
               next_s.nbit  = 4'h0;
            end else begin
               // start bit gone by mid-bit: treat as a glitch
               next_s.phase = RX_IDLE;
            end
         end
         RX_DATA: begin
            if (s.cnt != 16'h0) begin
               next_s.cnt = s.cnt - 16'h1;
            end else begin
               next_s.shreg = {s.sync2, s.shreg[8:1]};
               next_s.nbit  = s.nbit + 4'h1;
               next_s.cnt   = s.divisor - 16'h1;
               if (s.nbit == (s.nine_en ? 4'h8 : 4'h7)) begin
                  next_s.phase = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (s.cnt != 16'h0) begin
               next_s.cnt = s.cnt - 16'h1;
            end else begin
               done         = 1'b1;
               next_s.phase = RX_IDLE;
            end
         end
      endcase

      // eight-bit characters land one place high in the shifter
      ch = s.nine_en ? s.shreg : {1'b0, s.shreg[8:1]};
      entry_in.data      = ch;
      entry_in.frame_err = ~s.sync2;

      left = s.count - {1'b0, pop};
      if (done) begin
         if (s.addr_en && !ch[8]) begin
            push = 1'b0;
         end else if (left == 2'd2) begin
            // third full character with both slots taken
            next_s.overrun       = 1'b1;
            evt_set[EVT_OVR_BIT] = 1'b1;
         end else begin
            push = 1'b1;
         end
      end
      // framing errors raise no event of their own
      evt_set[EVT_RX_BIT] = push;

      if (pop) begin
         next_s.fifo[0] = s.fifo[1];
      end
      if (push) begin
         next_s.fifo[left[0]] = entry_in;
      end
      next_s.count = left + {1'b0, push};

      // either disable ends overrun; only port disable empties fifo
      if (!next_s.cont_en || !next_s.port_en) begin
         next_s.phase   = RX_IDLE;
         next_s.overrun = 1'b0;
      end
      if (!next_s.port_en) begin
         next_s.count = 2'd0;
         next_s.shreg = 9'h000;
      end

      // set wins over a clear in the same cycle
      next_s.evt_stat = (s.evt_stat & ~evt_clr) | evt_set;
      next_s.irq      = |(next_s.evt_stat & next_s.evt_en);
      next_s.rx_flag  = (next_s.count != 2'd0);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s         <= '0;
         s.divisor <= DIV_RESET;
         s.evt_en  <= EVT_EN_RESET;
         {s.addr_en, s.nine_en, s.cont_en, s.port_en} <= CTRL_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign dat_o                  = s.rdata;
   assign ack_o                  = s.ack;
   assign irq                    = s.irq;
   assign receive_interrupt_flag = s.rx_flag;

endmodule

`default_nettype wire

// >>> test/line_src.sv
// serial source that drives the receive line
`timescale 1ns/100ps
`default_nettype none
module line_src #(
   parameter int BIT = 8
) (
   // clock
   input  wire logic clk,
   // serial line, idles high
   output logic      line
);
   initial line = 1'b1;
   // lsb first; a low stop is used only to force a framing fault
   task automatic send(input logic [8:0] d, input int nb, input logic stop);
      line <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         line <= d[i];
         repeat (BIT) @(posedge clk);
      end
      line <= stop;
      repeat (BIT) @(posedge clk);
      line <= 1'b1;
      repeat (2 * BIT) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// >>> test/async_rx_chk.sv
// assertions on the bus, flag and interrupt ports
`timescale 1ns/100ps
`default_nettype none
module async_rx_chk
   import async_rx_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // bus
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   // line and flags
   input wire logic        rx_pin,
   input wire logic        irq,
   input wire logic        receive_interrupt_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic req = cyc_i && stb_i;
   wire logic st_rd = ack_o && !we_i && adr_i == STAT_OFS;
   sequence s_take; req && !ack_o; endsequence
   sequence s_pulse; ack_o ##1 !ack_o; endsequence
   a_ack_pulse: assert property (s_take |=> s_pulse)
      else $error("no single ack");
   a_ack_cause: assert property (ack_o |-> $past(req))
      else $error("ack without request");
   a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("data outside ack");
   a_unmapped_zero: assert property
      (ack_o && adr_i > EVT_EN_OFS |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_head_empty: assert property
      (st_rd && dat_o[5:4] == 2'h0 |-> !dat_o[0] && !dat_o[2])
      else $error("head flags with empty fifo");
   a_count_cap: assert property (st_rd |-> dat_o[5:4] <= 2'h2)
      else $error("fifo count above two");
   a_flag_fall: assert property
      ($fell(receive_interrupt_flag) |-> $past(req) || $past(req, 2))
      else $error("flag fell without access");
   // framing alone must never be the cause of a rise
   a_irq_cause: assert property ($rose(irq) |->
      (req && we_i) || $past(req && we_i) or ##[0:1] receive_interrupt_flag)
      else $error("irq rose without cause");
endmodule
bind async_rx async_rx_chk i_chk (.clk(clk), .nrst(nrst), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .rx_pin(rx_pin), .irq(irq),
   .receive_interrupt_flag(receive_interrupt_flag));
`default_nettype wire

// >>> test/async_rx_tb.sv
// self-checking bench of the serial receive port
`timescale 1ns/100ps
`default_nettype none
module async_rx_tb
   import async_rx_pkg::*;
;
   typedef struct packed {
      logic [3:0] ctrl;
      logic [8:0] ch;
      logic       stop;
      logic [5:0] st;
   } row_t;
   logic        clk, nrst, cyc_i, stb_i, we_i, ack_o, rx_pin, irq, rx_flag;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [8:0]  want;
   int          errors, samples_checked, cycles;
   // stat low bits: count, flag, ninth, overrun, framing
   row_t rows [6] = '{
      '{4'h3, 9'h0a5, 1'b1, 6'h18}, '{4'h3, 9'h15a, 1'b1, 6'h18},
      '{4'h7, 9'h1c3, 1'b1, 6'h1c}, '{4'h7, 9'h03c, 1'b0, 6'h19},
      '{4'hf, 9'h1e1, 1'b1, 6'h1c}, '{4'hf, 9'h0e1, 1'b1, 6'h00}};
   async_rx i_dut (.clk(clk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .rx_pin(rx_pin), .irq(irq),
      .receive_interrupt_flag(rx_flag));
   line_src #(.BIT(8)) i_src (.clk(clk), .line(rx_pin));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      do @(posedge clk); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
      nrst = 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      bus(0, CTRL_OFS, 0);
      chk("ctrl", 32'h0, q);
      bus(0, DIV_OFS, 0);
      chk("div", {16'h0, DIV_RESET}, q);
      bus(0, EVT_EN_OFS, 0);
      chk("evt_en", 32'h0, q);
      bus(0, 8'h20, 0);
      chk("unmapped", 32'h0, q);
      // short bit time keeps the run brief
      bus(1, DIV_OFS, 32'h8);
      bus(1, EVT_EN_OFS, 32'h2);
      $display("reset test done");
      foreach (rows[i]) begin
         bus(1, CTRL_OFS, {28'h0, rows[i].ctrl});
         i_src.send(rows[i].ch, rows[i].ctrl[2] ? 9 : 8, rows[i].stop);
         bus(0, STAT_OFS, 0);
         chk("stat", {26'h0, rows[i].st}, {26'h0, q[5:0]});
         chk("flag", {31'h0, rows[i].st[3]}, {31'h0, rx_flag});
         chk("irq", 32'h0, {31'h0, irq});
         if (rows[i].st[4]) begin
            bus(0, DATA_OFS, 0);
            want = rows[i].ch & {rows[i].ctrl[2], 8'hff};
            chk("data", {23'h0, want}, q);
            chk("popped", 32'h0, {31'h0, rx_flag});
         end
      end
      $display("row test done");
      bus(1, CTRL_OFS, 32'h3);
      i_src.send(9'h011, 8, 1'b0);
      i_src.send(9'h022, 8, 1'b1);
      i_src.send(9'h033, 8, 1'b1);
      bus(0, STAT_OFS, 0);
      chk("overrun", 32'h2b, {26'h0, q[5:0]});
      chk("irq set", 32'h1, {31'h0, irq});
      i_src.send(9'h044, 8, 1'b1);
      bus(1, CTRL_OFS, 32'h1);
      bus(0, STAT_OFS, 0);
      chk("keep", 32'h29, {26'h0, q[5:0]});
      bus(0, DATA_OFS, 0);
      chk("head", 32'h11, q);
      bus(0, STAT_OFS, 0);
      chk("next", 32'h18, {26'h0, q[5:0]});
      bus(0, EVT_OFS, 0);
      chk("events", 32'h3, q);
      bus(1, EVT_CLR_OFS, 32'h3);
      chk("irq clr", 32'h0, {31'h0, irq});
      bus(1, CTRL_OFS, 32'h3);
      repeat (3) i_src.send(9'h055, 8, 1'b1);
      bus(1, CTRL_OFS, 32'h2);
      bus(0, STAT_OFS, 0);
      chk("port off", 32'h0, {26'h0, q[5:0]});
      bus(1, CTRL_OFS, 32'h3);
      i_src.send(9'h066, 8, 1'b1);
      bus(0, DATA_OFS, 0);
      chk("again", 32'h66, q);
      $display("error test done");
      // address match, then a data character with filtering off
      bus(1, CTRL_OFS, 32'hf);
      i_src.send(9'h1a5, 9, 1'b1);
      bus(0, STAT_OFS, 0);
      chk("addr hit", 32'h1c, {26'h0, q[5:0]});
      bus(1, CTRL_OFS, 32'h7);
      i_src.send(9'h03c, 9, 1'b1);
      bus(1, CTRL_OFS, 32'hf);
      i_src.send(9'h0c3, 9, 1'b1);
      bus(0, STAT_OFS, 0);
      chk("addr msg", 32'h2c, {26'h0, q[5:0]});
      bus(0, DATA_OFS, 0);
      chk("addr data", 32'h1a5, q);
      bus(0, STAT_OFS, 0);
      chk("msg data", 32'h18, {26'h0, q[5:0]});
      $display("address test done");
      // reset in mid-run with a character still unread
      chk("irq held", 32'h1, {31'h0, irq});
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("rst irq", 32'h0, {31'h0, irq});
      chk("rst flag", 32'h0, {31'h0, rx_flag});
      nrst <= 1'b1;
      @(posedge clk);
      bus(0, CTRL_OFS, 0);
      chk("rst ctrl", 32'h0, q);
      bus(0, STAT_OFS, 0);
      chk("rst stat", 32'h0, q);
      bus(0, DIV_OFS, 0);
      chk("rst div", {16'h0, DIV_RESET}, q);
      $display("mid reset test done");
      stop_test();
   end
endmodule
`default_nettype wire
